// *** dv/test_rtc_control_status_flags.sv ***
// self-checking bench for the rtc control bits and status register
`timescale 1ns/1ps
module test_rtc_control_status_flags;
  localparam logic [7:0] sa = rtc_flags_pkg::status_offset;
  localparam logic [7:0] ca = rtc_flags_pkg::ctrl_offset;
  logic clk, rst, wr, rd, t1, t2, t3, st, mref, ala, alb, shp;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic seen, sload, wtick;
  int mismatches, checks, cycles, n;
  rtc_control_status_flags dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tamper_in1(t1), .tamper_in2(t2), .tamper_in3(t3), .stamp_in(st),
    .mains_ref_in(mref), .alarm_a_match(ala), .alarm_b_match(alb), .shift_pending(shp),
    .mains_ref_seen(seen), .shadow_load(sload), .wake_tick(wtick));
  // free-running bus clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard: whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // single-cycle strobes, changed just after the edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk); // return on an edge so the next drive lands there
  endtask
  // poll status under a mask; a limit of one read checks an immediate value
  task automatic poll(input string nm, input logic [31:0] m, input logic [31:0] e, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd_reg(sa, v);
      if ((v & m) === e) break;
    end
    chk(nm, e, v & m);
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  task automatic t_reset();
    poll("status reset", 32'hFFFFFFDF, 32'h00000007, 1);
    rd_reg(ca, v);
    chk("ctrl reset", 32'h00000000, v);
    rd_reg(8'h40, v);
    chk("unmapped read", 32'h00000000, v);
  endtask
  task automatic t_tamper();
    t1 <= 1'b1;
    t2 <= 1'b1;
    t3 <= 1'b1;
    settle();
    poll("tamper set", 32'h0000E000, 32'h0000E000, 1);
    wr_reg(sa, 32'hFFFFFF7F);
    poll("write one keeps", 32'h0000E000, 32'h0000E000, 1);
    wr_reg(sa, 32'hFFFFDF7F);
    poll("tamper1 clear", 32'h0000E000, 32'h0000C000, 1);
    wr_reg(sa, 32'h00000000);
    poll("all clear", 32'h0000FF00, 32'h00000000, 1);
  endtask
  task automatic t_stamp();
    wr_reg(ca, 32'h00000800);
    st <= 1'b1;
    settle();
    poll("stamp rise", 32'h00001800, 32'h00000800, 1);
    st <= 1'b0;
    settle();
    st <= 1'b1;
    settle();
    poll("stamp overrun", 32'h00001800, 32'h00001800, 1);
    wr_reg(sa, 32'h0000F77F);
    wr_reg(sa, 32'h0000E77F);
    poll("stamp cleared", 32'h00001800, 32'h00000000, 1);
    wr_reg(ca, 32'h00000000);
    wr_reg(ca, 32'h00000008); // edge changed only while stamping is off
    wr_reg(ca, 32'h00000808);
    st <= 1'b0;
    settle();
    poll("stamp fall", 32'h00001800, 32'h00000800, 1);
    wr_reg(sa, 32'h00000000);
    wr_reg(ca, 32'h00000000);
  endtask
  task automatic t_alarm();
    ala <= 1'b1;
    alb <= 1'b1;
    settle();
    poll("alarm set", 32'h00000300, 32'h00000300, 1);
    ala <= 1'b0;
    alb <= 1'b0;
    wr_reg(sa, 32'h0000FE00);
    poll("alarm a clear", 32'h00000300, 32'h00000200, 1);
    wr_reg(sa, 32'h00000000);
    poll("alarm b clear", 32'h00000300, 32'h00000000, 1);
  endtask
  task automatic t_init();
    wr_reg(sa, 32'h00000080);
    poll("init ready", 32'h000000E0, 32'h000000C0, 100);
    wr_reg(sa, 32'h00000000);
    poll("init leave", 32'h000000C0, 32'h00000000, 100);
  endtask
  task automatic t_recal();
    wr_reg(rtc_flags_pkg::calib_offset, 32'h00000000);
    poll("recal set", 32'h00010000, 32'h00010000, 1);
    poll("recal done", 32'h00010000, 32'h00000000, 150);
  endtask
  task automatic t_shadow();
    repeat (3) gap(1'b1);
    chk("shadow period", 32'h00000032, 32'(n));
    poll("shadow synced", 32'h00000020, 32'h00000020, 60);
    wr_reg(ca, 32'h00000020); // bypass as a slow bus clock would need
    poll("bypass clears", 32'h00000020, 32'h00000000, 5);
    shp <= 1'b1;
    wr_reg(ca, 32'h00000000);
    repeat (100) @(posedge clk);
    poll("shift holds", 32'h00000028, 32'h00000008, 1);
    shp <= 1'b0;
  endtask
  task automatic t_mains();
    wr_reg(ca, 32'h00000010); // prescaler left at its 0x00FF reset value
    mref <= 1'b1;
    settle();
    chk("mains seen", 32'h1, {31'h0, seen});
    wr_reg(ca, 32'h00000000);
    mref <= 1'b0;
    repeat (2) @(posedge clk);
    chk("mains off", 32'h0, {31'h0, seen});
  endtask
  // cycles from one pulse to the next: wake tick, or shadow load when sel is set
  task automatic gap(input logic sel);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while ((sel ? sload : wtick) !== 1'b1 && n < 1000);
  endtask
  task automatic t_wake();
    for (int c = 0; c < 4; c++) begin
      wr_reg(ca, 32'(c));
      repeat (3) gap(1'b0);
      chk("wake period", 32'((16 >> c) * 25), 32'(n));
    end
    wr_reg(rtc_flags_pkg::reload_offset, 32'h00000001);
    wr_reg(ca, 32'h00000403);
    wr_reg(rtc_flags_pkg::reload_offset, 32'h00000005); // refused while the timer runs
    rd_reg(rtc_flags_pkg::reload_offset, v);
    chk("reload locked", 32'h00000001, v);
    poll("wake flag", 32'h00000400, 32'h00000400, 70);
    wr_reg(sa, 32'h00000000); // cleared well inside the reload period
    poll("wake clear", 32'h00000400, 32'h00000000, 1);
    poll("wake again", 32'h00000400, 32'h00000400, 70);
    wr_reg(ca, 32'h00000000);
  endtask
  // prescaler factor only takes in init; a short factor makes the 10x tick timeable
  task automatic t_onehz();
    wr_reg(rtc_flags_pkg::prescale_offset, 32'h00000003);
    rd_reg(rtc_flags_pkg::prescale_offset, v);
    chk("prescale refused", 32'h000000FF, v);
    wr_reg(sa, 32'h00000080);
    poll("init again", 32'h00000040, 32'h00000040, 100);
    wr_reg(rtc_flags_pkg::prescale_offset, 32'h00000003);
    wr_reg(sa, 32'h00000000);
    rd_reg(rtc_flags_pkg::prescale_offset, v);
    chk("prescale written", 32'h00000003, v);
    for (int c = 4; c < 6; c++) begin
      wr_reg(ca, 32'(c));
      repeat (3) gap(1'b0);
      chk("one hz period", 32'h00000064, 32'(n));
    end
    wr_reg(ca, 32'h00000000);
  endtask
  // inputs at time zero, then 20 cycles of reset
  initial begin
    {rst, wr, rd, t1, t2, t3, st, mref, ala, alb, shp} = 11'h400;
    addr = 8'h00;
    wdata = 32'h00000000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tamper();
    t_stamp();
    t_alarm();
    t_init();
    t_recal();
    t_shadow();
    t_mains();
    t_wake();
    t_onehz();
    stop_test();
  end
endmodule // test_rtc_control_status_flags

// *** rtl/rtc_control_status_flags.sv ***
// rtc control bits and initialization/event status register
//
// Summary of operation
// - control bit 4 enables mains reference clock detection
// - control bit 3 picks stamp edge: 0 rising, 1 falling
// - wake select: 000/001/010/011 divide by 16/8/4/2, 10x one-hz tick
// - calibration write raises bit 16, blocks the register until processed
// - tamper pins set bits 15..13; software writes 0 to clear
// - stamp event while stamp flag set raises overrun bit 12
// - every stamp event sets bit 11; writing 0 clears it
// - wake counter reaching zero sets bit 10; writing 0 clears it
// - alarm matches set bits 9 and 8; writing 0 clears them
// - bit 7 low runs free, high requests initialization mode
// - bit 6 reads 1 only while in the initialization state
// - bit 5 set when calendar copied into shadow registers
// - bit 5 held clear in init, shift pending, or bypass
// - shadow refresh every two kernel ticks unless bypass, init or shift pending
// - wake flag raised every reload plus one wake ticks while enabled
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module rtc_control_status_flags #(
  parameter int reload_width = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic tamper_in1,
  input wire logic tamper_in2,
  input wire logic tamper_in3,
  input wire logic stamp_in,
  input wire logic mains_ref_in,
  input wire logic alarm_a_match,
  input wire logic alarm_b_match,
  input wire logic shift_pending,
  output logic mains_ref_seen,
  output logic shadow_load,
  output logic wake_tick
);
  // the status and reload layout is fixed at sixteen reload bits
  if (reload_width != 16) begin : g_width_check
    $error("reload_width must be 16");
  end

  typedef enum logic [1:0] {run_st, entering_st, init_st} init_type;

  logic [31:0] ctrl_q, ctrl_d;
  logic [16:0] flags_q, flags_d;
  logic [15:0] reload_q, reload_d;
  logic [14:0] prescale_q, prescale_d;
  logic [16:0] wake_cnt_q, wake_cnt_d;
  logic [7:0] kdiv_q, kdiv_d;
  logic [3:0] wdiv_q, wdiv_d;
  logic [14:0] sdiv_q, sdiv_d;
  logic [1:0] recal_q, recal_d;
  logic [1:0] shadow_q, shadow_d;
  logic [1:0] ticks_q, ticks_d;
  logic [31:0] rdata_q, rdata_d;
  logic ref_seen_q, ref_seen_d;
  init_type state_q, state_d;
  logic kt, onehz, wake_en, wake_zero;
  logic t1, t2, t3, st_r, st_f, mr_r, aa_r, ab_r;
  logic stamp_ev, aa_q, ab_q;
  logic wr_stat, wr_ctrl, wr_cal;

  // async inputs each pass the three-flop synchroniser
  rtc_pin_sync u_t1 (.clk(clk), .rst(rst), .pin(tamper_in1), .level(), .rise(t1), .fall());
  rtc_pin_sync u_t2 (.clk(clk), .rst(rst), .pin(tamper_in2), .level(), .rise(t2), .fall());
  rtc_pin_sync u_t3 (.clk(clk), .rst(rst), .pin(tamper_in3), .level(), .rise(t3), .fall());
  rtc_pin_sync u_ts (.clk(clk), .rst(rst), .pin(stamp_in), .level(), .rise(st_r), .fall(st_f));
  rtc_pin_sync u_mr (.clk(clk), .rst(rst), .pin(mains_ref_in), .level(), .rise(mr_r), .fall());

  // alarm matches are same-clock: edge detect only
  assign aa_r = alarm_a_match & ~aa_q;
  assign ab_r = alarm_b_match & ~ab_q;

  assign wr_stat = wr && (addr == rtc_flags_pkg::status_offset);
  assign wr_ctrl = wr && (addr == rtc_flags_pkg::ctrl_offset);
  // calibration register is blocked while a recalibration is pending
  assign wr_cal = wr && (addr == rtc_flags_pkg::calib_offset) && !flags_q[16];

  // kernel tick divider, then wake clock selection
  assign kt = (kdiv_q == 8'(rtc_flags_pkg::kernel_div - 1));
  // at or past the factor, so shrinking it in init cannot strand the counter for a full wrap
  assign onehz = kt && (sdiv_q >= prescale_q);
  assign wake_en = ctrl_q[rtc_flags_pkg::wake_en_bit];
  always_comb begin
    case (ctrl_q[2:0])
      3'h0: wake_tick = kt && (wdiv_q[3:0] == 4'hF);
      3'h1: wake_tick = kt && (wdiv_q[2:0] == 3'h7);
      3'h2: wake_tick = kt && (wdiv_q[1:0] == 2'h3);
      3'h3: wake_tick = kt && wdiv_q[0];
      default: wake_tick = onehz;
    endcase
  end
  assign wake_zero = wake_en && wake_tick && (wake_cnt_q == 17'h0_0000);

  // a stamp event only counts when stamping is on; edge per select bit
  assign stamp_ev = ctrl_q[rtc_flags_pkg::stamp_en_bit] &&
    (ctrl_q[rtc_flags_pkg::stamp_edge_bit] ? st_f : st_r);

  // timing, wake counter, init and shadow state
  always_comb begin
    kdiv_d = kt ? 8'h00 : kdiv_q + 8'h01;
    wdiv_d = kt ? wdiv_q + 4'h1 : wdiv_q;
    sdiv_d = kt ? (onehz ? 15'h0000 : sdiv_q + 15'h0001) : sdiv_q;
    wake_cnt_d = wake_cnt_q;
    if (!wake_en) begin
      wake_cnt_d = {1'b0, reload_q};
    end else if (wake_tick) begin
      // reload then count down: period is reload plus one ticks
      wake_cnt_d = wake_zero ? {1'b0, reload_q} : wake_cnt_q - 17'h0_0001;
    end
    state_d = state_q;
    ticks_d = ticks_q;
    case (state_q)
      run_st: if (flags_q[rtc_flags_pkg::init_req_bit]) begin
        state_d = entering_st;
        ticks_d = 2'(rtc_flags_pkg::init_ticks);
      end
      entering_st: if (!flags_q[rtc_flags_pkg::init_req_bit]) begin
        state_d = run_st;
      end else if (kt) begin
        if (ticks_q == 2'h1) state_d = init_st;
        ticks_d = ticks_q - 2'h1;
      end
      default: if (!flags_q[rtc_flags_pkg::init_req_bit]) state_d = run_st;
    endcase
    // shadow copy every second kernel tick, skipped when bypassed or held
    shadow_d = kt ? shadow_q + 2'h1 : shadow_q;
    shadow_load = kt && shadow_q[0] && !ctrl_q[rtc_flags_pkg::bypass_bit] &&
      (state_q == run_st) && !shift_pending;
    recal_d = recal_q;
    if (wr_cal) recal_d = 2'(rtc_flags_pkg::recal_ticks);
    else if (kt && recal_q != 2'h0) recal_d = recal_q - 2'h1;
    // detection tracks reference edges only while enabled
    ref_seen_d = ctrl_q[rtc_flags_pkg::mains_ref_bit] ? (ref_seen_q | mr_r) : 1'b0;
  end

  // status flags: set beats clear, writing 1 keeps a flag
  always_comb begin
    flags_d = flags_q;
    if (wr_stat) begin
      for (int i = 8; i <= 15; i++) begin
        if (!wdata[i]) flags_d[i] = 1'b0;
      end
      flags_d[rtc_flags_pkg::synced_bit] = flags_q[5] & wdata[5];
      flags_d[rtc_flags_pkg::init_req_bit] = wdata[rtc_flags_pkg::init_req_bit];
    end
    if (t3) flags_d[rtc_flags_pkg::tamper3_bit] = 1'b1;
    if (t2) flags_d[rtc_flags_pkg::tamper2_bit] = 1'b1;
    if (t1) flags_d[rtc_flags_pkg::tamper1_bit] = 1'b1;
    if (stamp_ev && flags_q[rtc_flags_pkg::stamp_bit]) flags_d[12] = 1'b1;
    if (stamp_ev) flags_d[rtc_flags_pkg::stamp_bit] = 1'b1;
    if (wake_zero) flags_d[rtc_flags_pkg::wake_flag_bit] = 1'b1;
    if (ab_r) flags_d[rtc_flags_pkg::alarm_b_bit] = 1'b1;
    if (aa_r) flags_d[rtc_flags_pkg::alarm_a_bit] = 1'b1;
    if (shadow_load) flags_d[rtc_flags_pkg::synced_bit] = 1'b1;
    // held clear in init, shift pending or bypass
    if (state_q != run_st || shift_pending || ctrl_q[rtc_flags_pkg::bypass_bit]) begin
      flags_d[rtc_flags_pkg::synced_bit] = 1'b0;
    end
    flags_d[rtc_flags_pkg::init_rdy_bit] = (state_d == init_st);
    flags_d[rtc_flags_pkg::recal_bit] = (recal_d != 2'h0);
    flags_d[rtc_flags_pkg::shift_bit] = shift_pending;
  end

  // control, reload, prescaler writes and read mux
  always_comb begin
    ctrl_d = wr_ctrl ? wdata : ctrl_q;
    reload_d = (wr && addr == rtc_flags_pkg::reload_offset && !wake_en) ? wdata[15:0] : reload_q;
    prescale_d = prescale_q;
    if (wr && addr == rtc_flags_pkg::prescale_offset && state_q == init_st) begin
      prescale_d = wdata[14:0];
    end
    rdata_d = 32'h0000_0000;
    if (rd) begin
      if (addr == rtc_flags_pkg::ctrl_offset) rdata_d = ctrl_q;
      else if (addr == rtc_flags_pkg::status_offset) rdata_d = {15'h0000, flags_q};
      else if (addr == rtc_flags_pkg::reload_offset) rdata_d = {16'h0000, reload_q};
      else if (addr == rtc_flags_pkg::prescale_offset) rdata_d = {17'h0_0000, prescale_q};
      else rdata_d = 32'h0000_0000;
    end
  end

  // registers only; every next value comes from the blocks above, except aa_q and ab_q, which take the alarm inputs directly
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= rtc_flags_pkg::ctrl_reset;
      flags_q <= rtc_flags_pkg::status_reset[16:0];
      reload_q <= rtc_flags_pkg::reload_reset;
      prescale_q <= rtc_flags_pkg::prescale_reset;
      wake_cnt_q <= 17'h0_FFFF;
      kdiv_q <= 8'h00;
      wdiv_q <= 4'h0;
      sdiv_q <= 15'h0000;
      recal_q <= 2'h0;
      shadow_q <= 2'h0;
      ticks_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
      ref_seen_q <= 1'b0;
      state_q <= run_st;
      aa_q <= 1'b0;
      ab_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      flags_q <= flags_d;
      reload_q <= reload_d;
      prescale_q <= prescale_d;
      wake_cnt_q <= wake_cnt_d;
      kdiv_q <= kdiv_d;
      wdiv_q <= wdiv_d;
      sdiv_q <= sdiv_d;
      recal_q <= recal_d;
      shadow_q <= shadow_d;
      ticks_q <= ticks_d;
      rdata_q <= rdata_d;
      ref_seen_q <= ref_seen_d;
      state_q <= state_d;
      aa_q <= alarm_a_match;
      ab_q <= alarm_b_match;
    end
  end

  // read data and detection flag come straight from flops
  assign rdata = rdata_q;
  assign mains_ref_seen = ref_seen_q;

  // assertions: init handshake and what it locks
  a_ready_in_init: assert property (@(posedge clk) disable iff (rst)
    flags_q[6] |-> state_q == init_st) else $error("ready outside init");
  a_init_leave: assert property (@(posedge clk) disable iff (rst)
    !flags_q[7] |=> !flags_q[6]) else $error("ready without request");
  a_prescale_locked: assert property (@(posedge clk) disable iff (rst)
    state_q != init_st |=> $stable(prescale_q)) else $error("prescale changed outside init");
  // assertions: shadow synchronisation
  a_synced_bypass: assert property (@(posedge clk) disable iff (rst)
    $past(ctrl_q[5]) && !rst |-> !flags_q[5]) else $error("synced while bypass");
  a_synced_init: assert property (@(posedge clk) disable iff (rst)
    state_q != run_st |=> !flags_q[5]) else $error("synced in init");
  a_synced_shift: assert property (@(posedge clk) disable iff (rst)
    shift_pending |=> !flags_q[5]) else $error("synced while shift pending");
  a_synced_sets: assert property (@(posedge clk) disable iff (rst)
    shadow_load |=> flags_q[5]) else $error("synced flag not set");
  a_shadow_bypass: assert property (@(posedge clk) disable iff (rst)
    ctrl_q[5] |-> !shadow_load) else $error("shadow load while bypass");
  // assertions: hardware events set their flags, ahead of any clear
  a_stamp_sets: assert property (@(posedge clk) disable iff (rst)
    stamp_ev |=> flags_q[11]) else $error("stamp flag not set");
  a_overrun_sets: assert property (@(posedge clk) disable iff (rst)
    stamp_ev && flags_q[11] |=> flags_q[12]) else $error("overrun missed");
  a_wake_sets: assert property (@(posedge clk) disable iff (rst)
    wake_zero |=> flags_q[10]) else $error("wake flag missed");
  a_tamper_sets: assert property (@(posedge clk) disable iff (rst)
    t1 |=> flags_q[13]) else $error("tamper1 missed");
  a_tamper2_sets: assert property (@(posedge clk) disable iff (rst)
    t2 |=> flags_q[14]) else $error("tamper2 missed");
  a_tamper3_sets: assert property (@(posedge clk) disable iff (rst)
    t3 |=> flags_q[15]) else $error("tamper3 missed");
  a_alarm_sets: assert property (@(posedge clk) disable iff (rst)
    aa_r |=> flags_q[8]) else $error("alarm a missed");
  a_alarm_b_sets: assert property (@(posedge clk) disable iff (rst)
    ab_r |=> flags_q[9]) else $error("alarm b missed");
  // assertions: software writes keep ones and clear zeros
  a_write_one_keeps: assert property (@(posedge clk) disable iff (rst)
    wr_stat && wdata[9] && flags_q[9] |=> flags_q[9]) else $error("flag lost");
  a_write_zero_clears: assert property (@(posedge clk) disable iff (rst)
    wr_stat && !wdata[8] && !aa_r |=> !flags_q[8]) else $error("alarm a not cleared");
  a_tamper_clear: assert property (@(posedge clk) disable iff (rst)
    wr_stat && !wdata[13] && !t1 |=> !flags_q[13]) else $error("tamper1 not cleared");
  a_stamp_clear: assert property (@(posedge clk) disable iff (rst)
    wr_stat && !wdata[11] && !stamp_ev |=> !flags_q[11]) else $error("stamp not cleared");
  a_wake_clear: assert property (@(posedge clk) disable iff (rst)
    wr_stat && !wdata[10] && !wake_zero |=> !flags_q[10]) else $error("wake not cleared");
  a_overrun_clear: assert property (@(posedge clk) disable iff (rst)
    wr_stat && !wdata[12] && !(stamp_ev && flags_q[11]) |=> !flags_q[12])
    else $error("overrun not cleared");
  // assertions: wake counter
  a_reload_locked: assert property (@(posedge clk) disable iff (rst)
    wake_en |=> $stable(reload_q)) else $error("reload changed while running");
  a_wake_reload: assert property (@(posedge clk) disable iff (rst)
    wake_zero |=> wake_cnt_q == {1'b0, $past(reload_q)}) else $error("wake reload missed");
  a_wake_count: assert property (@(posedge clk) disable iff (rst)
    wake_en && wake_tick && wake_cnt_q != 17'h0_0000 |=> wake_cnt_q == $past(wake_cnt_q) - 17'h0_0001)
    else $error("wake count step wrong");
  // assertions: recalibration pending, held then released
  sequence s_recal_held;
    flags_q[16] ##1 flags_q[16];
  endsequence
  a_recal_raise: assert property (@(posedge clk) disable iff (rst)
    wr_cal |=> s_recal_held) else $error("recal not pending");
  a_recal_ends: assert property (@(posedge clk) disable iff (rst)
    flags_q[16] |-> ##[1:100] !flags_q[16]) else $error("recal never ends");
  // assertions: mains reference detection
  a_ref_off: assert property (@(posedge clk) disable iff (rst)
    !ctrl_q[4] |=> !mains_ref_seen) else $error("reference seen while disabled");
endmodule // rtc_control_status_flags

// *** rtl/rtc_flags_pkg.sv ***
// package: offsets, field positions, reset values and timing for the rtc control/status block
package rtc_flags_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] ctrl_offset = 8'h08;
  localparam logic [7:0] status_offset = 8'h0C;
  localparam logic [7:0] calib_offset = 8'h20;
  localparam logic [7:0] reload_offset = 8'h14;
  localparam logic [7:0] prescale_offset = 8'h10;
  // control fields
  localparam int wake_sel_lsb = 0;
  localparam int stamp_edge_bit = 3;
  localparam int mains_ref_bit = 4;
  localparam int bypass_bit = 5;
  localparam int wake_en_bit = 10;
  localparam int stamp_en_bit = 11;
  // status fields
  localparam int recal_bit = 16;
  localparam int tamper3_bit = 15;
  localparam int tamper2_bit = 14;
  localparam int tamper1_bit = 13;
  localparam int overrun_bit = 12;
  localparam int stamp_bit = 11;
  localparam int wake_flag_bit = 10;
  localparam int alarm_b_bit = 9;
  localparam int alarm_a_bit = 8;
  localparam int init_req_bit = 7;
  localparam int init_rdy_bit = 6;
  localparam int synced_bit = 5;
  localparam int shift_bit = 3;
  // reset values
  localparam logic [31:0] status_reset = 32'h0000_0007;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [15:0] reload_reset = 16'hFFFF;
  localparam logic [14:0] prescale_reset = 15'h00FF;
  // timing: kernel tick is a divided enable; recal takes a few kernel ticks
  localparam int clk_hz = 25_000_000;
  localparam int kernel_hz = 1_000_000;
  localparam int kernel_div = clk_hz / kernel_hz;
  localparam int recal_ticks = 3;
  localparam int init_ticks = 2;
endpackage

// *** rtl/rtc_pin_sync.sv ***
// three-stage pin synchroniser with agreement-based change detection
`timescale 1ns/1ps
module rtc_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_q, s2_q, s3_q, level_q;
  logic level_d;

  // change counts once stages two and three agree
  always_comb begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign level = level_q;
  assign rise = level_d & ~level_q;
  assign fall = ~level_d & level_q;
endmodule // rtc_pin_sync
